/* File: verilog/uvh_host_port.sv */
// I2C register port, sequencer modes and interrupt line of the UV sensor
// How it works
// - UV result times 100 lands in aux
// - Command 0x12 at 0x18 recovers calibration if key 0x07 holds 0x17
// - Calibration fills registers 0x22 to 0x2D
// - Interrupt output only ever pulls low
// - Acknowledge own 7-bit address 0x60
// - Answer general call, reset on 0x06
// - Only 7-bit addressing, never 10-bit
// - First write byte sets pointer, rest store
// - Pointer-only write prepares a later read
// - Reads stream registers from current pointer
// - Pointer bits 5:0, bit 6 disables increment
// - Increment per byte unless disabled
// - Reset goes off, then straight to init
// - After init enter standby, port live
// - Interrupt holds until host clears it
// - Only command writes wake the sequencer
// - Reply low nibble counts, high nibble errors
`timescale 1ns/1ps
module uvh_host_port #(
  parameter int          UV_CYC   = uvh_pkg::UV_CYC,
  parameter int          INIT_CYC = uvh_pkg::INIT_CYC,
  parameter logic [95:0] CAL_DATA = 96'h0B0A09080706050403020100
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  // I2C pins
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_o,
  output logic             o_sda_oe,
  // Interrupt pin
  output logic             o_int_o,
  output logic             o_int_oe,
  // Measurement core
  input  wire logic [15:0] i_uv_x100,
  output logic             o_standby
);
  localparam int MX = (UV_CYC > INIT_CYC) ? UV_CYC : INIT_CYC;
  localparam int CW = $clog2(MX + 1);
  if (UV_CYC < 1 || INIT_CYC < 1) begin : g_chk
    $error("cycle counts must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus events
  logic sc1_r, sc2_r, sc3_r, sd1_r, sd2_r, sd3_r;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      {sc1_r, sc2_r, sc3_r, sd1_r, sd2_r, sd3_r} <= 6'h3F;
    end else begin
      {sc1_r, sc2_r, sc3_r} <= {i_scl, sc1_r, sc2_r};
      {sd1_r, sd2_r, sd3_r} <= {i_sda, sd1_r, sd2_r};
    end
  end
  logic rise, fall, start, stop;
  assign rise  = sc2_r & ~sc3_r;
  assign fall  = ~sc2_r & sc3_r;
  assign start = sc2_r & sc3_r & sd3_r & ~sd2_r;
  assign stop  = sc2_r & sc3_r & ~sd3_r & sd2_r;

  ////////////////////////////////////////////////////////////////////////
  // Register array and shared state
  logic [7:0]       mem [64];
  uvh_pkg::uvh_seq_t sq_r, sq_nxt;
  logic             irq_r, irq_nxt, irq_set, irq_clr;
  logic             live;
  logic [7:0]       rd_byte;
  assign live    = !(sq_r inside {uvh_pkg::SQ_OFF, uvh_pkg::SQ_INIT});
  assign o_standby = (sq_r == uvh_pkg::SQ_STBY);

  ////////////////////////////////////////////////////////////////////////
  // I2C slave
  uvh_pkg::uvh_i2c_t ist_r, ist_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [5:0] ptr_r, ptr_nxt;
  logic       oe_r, oe_nxt, rw_r, rw_nxt, gc_r, gc_nxt, first_r, first_nxt;
  logic       aid_r, aid_nxt, wr_en, cmd_wr, gc_rst;

  assign rd_byte = (ptr_r == uvh_pkg::REG_IRQ) ? {7'h00, irq_r} : mem[ptr_r];

  always_comb begin
    ist_nxt   = ist_r;
    bit_nxt   = bit_r;
    sh_nxt    = sh_r;
    ptr_nxt   = ptr_r;
    oe_nxt    = oe_r;
    rw_nxt    = rw_r;
    gc_nxt    = gc_r;
    first_nxt = first_r;
    aid_nxt   = aid_r;
    wr_en     = 1'b0;
    cmd_wr    = 1'b0;
    gc_rst    = 1'b0;
    irq_clr   = 1'b0;
    if (!live || stop) begin
      ist_nxt = uvh_pkg::IS_IDLE;
      oe_nxt  = 1'b0;
    end else if (start) begin
      ist_nxt = uvh_pkg::IS_ADDR;
      bit_nxt = 3'h0;
      oe_nxt  = 1'b0;
    end else begin
      unique case (ist_r)
        uvh_pkg::IS_IDLE: ;
        uvh_pkg::IS_ADDR, uvh_pkg::IS_WR: if (rise) begin
          sh_nxt  = {sh_r[6:0], sd2_r};
          bit_nxt = bit_r + 3'h1;
          if (bit_r == 3'h7) begin
            ist_nxt = (ist_r == uvh_pkg::IS_ADDR) ? uvh_pkg::IS_AACK : uvh_pkg::IS_WACK;
          end
        end
        uvh_pkg::IS_AACK: if (fall) begin
          if (oe_r) begin
            bit_nxt = 3'h0;
            if (rw_r) begin
              sh_nxt  = rd_byte;
              oe_nxt  = ~rd_byte[7];
              ist_nxt = uvh_pkg::IS_RD;
            end else begin
              oe_nxt  = 1'b0;
              ist_nxt = uvh_pkg::IS_WR;
            end
          end else if (sh_r[7:1] == uvh_pkg::OWN_ADDR || sh_r == 8'h00) begin
            oe_nxt    = 1'b1;
            rw_nxt    = sh_r[0];
            gc_nxt    = (sh_r[7:1] == uvh_pkg::GC_ADDR);
            first_nxt = 1'b1;
          end else begin
            ist_nxt = uvh_pkg::IS_IDLE;
          end
        end
        uvh_pkg::IS_WACK: if (fall) begin
          if (oe_r) begin
            oe_nxt  = 1'b0;
            bit_nxt = 3'h0;
            ist_nxt = uvh_pkg::IS_WR;
          end else begin
            oe_nxt = 1'b1;
            if (gc_r) begin
              gc_rst = (sh_r == uvh_pkg::GC_RESET);
            end else if (first_r) begin
              ptr_nxt   = sh_r[5:0];
              aid_nxt   = sh_r[uvh_pkg::AI_BIT];
              first_nxt = 1'b0;
            end else begin
              wr_en   = 1'b1;
              cmd_wr  = (ptr_r == uvh_pkg::REG_CMD);
              irq_clr = (ptr_r == uvh_pkg::REG_IRQ) && sh_r[0];
              if (!aid_r) begin
                ptr_nxt = ptr_r + 6'h01;
              end
            end
          end
        end
        uvh_pkg::IS_RD: begin
          if (rise) begin
            bit_nxt = bit_r + 3'h1;
            if (bit_r == 3'h7) begin
              ist_nxt = uvh_pkg::IS_RACK;
            end
          end else if (fall) begin
            sh_nxt = {sh_r[6:0], 1'b0};
            oe_nxt = ~sh_r[6];
          end
        end
        uvh_pkg::IS_RACK: if (fall) begin
          oe_nxt = 1'b0;
        end else if (rise) begin
          if (!aid_r) begin
            ptr_nxt = ptr_r + 6'h01;
          end
          ist_nxt = sd2_r ? uvh_pkg::IS_IDLE : uvh_pkg::IS_RNXT;
        end
        uvh_pkg::IS_RNXT: if (fall) begin
          sh_nxt  = rd_byte;
          oe_nxt  = ~rd_byte[7];
          bit_nxt = 3'h0;
          ist_nxt = uvh_pkg::IS_RD;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ist_r <= uvh_pkg::IS_IDLE;
      {bit_r, sh_r, ptr_r} <= 17'h00000;
      {oe_r, rw_r, gc_r, first_r, aid_r} <= 5'h00;
    end else begin
      ist_r <= ist_nxt;
      {bit_r, sh_r, ptr_r} <= {bit_nxt, sh_nxt, ptr_nxt};
      {oe_r, rw_r, gc_r, first_r, aid_r} <= {oe_nxt, rw_nxt, gc_nxt, first_nxt, aid_nxt};
    end
  end
  assign o_sda_o  = 1'b0;
  assign o_sda_oe = oe_r;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: modes, commands, calibration and UV result
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [3:0]    idx_r, idx_nxt;
  logic [7:0]    rv_r, rv_nxt, s_data;
  logic [15:0]   uv_r, uv_nxt;
  logic [5:0]    s_addr;
  logic          s_we, grant;
  logic [7:0]    resp_inc;
  assign resp_inc = {4'h0, mem[uvh_pkg::REG_RESP][3:0] + 4'h1};
  assign grant    = s_we & ~wr_en;

  always_comb begin
    sq_nxt  = sq_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    rv_nxt  = rv_r;
    uv_nxt  = uv_r;
    s_we    = 1'b0;
    s_addr  = uvh_pkg::REG_RESP;
    s_data  = rv_r;
    irq_set = 1'b0;
    unique case (sq_r)
      uvh_pkg::SQ_OFF: begin
        sq_nxt  = uvh_pkg::SQ_INIT;
        cnt_nxt = CW'(INIT_CYC - 1);
      end
      uvh_pkg::SQ_INIT: begin
        if (cnt_r == '0) begin
          sq_nxt = uvh_pkg::SQ_STBY;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      uvh_pkg::SQ_STBY: if (cmd_wr) begin
        idx_nxt = 4'h0;
        if (sh_r == uvh_pkg::CMD_RESET) begin
          sq_nxt = uvh_pkg::SQ_OFF;
        end else if (mem[uvh_pkg::REG_KEY] == uvh_pkg::KEY_VAL) begin
          sq_nxt = uvh_pkg::SQ_DONE;
          rv_nxt = {uvh_pkg::ERR_BADCMD, resp_inc[3:0]};
          if (sh_r == uvh_pkg::CMD_NOP) begin
            rv_nxt = 8'h00;
          end else if (sh_r == uvh_pkg::CMD_CAL) begin
            sq_nxt = uvh_pkg::SQ_CAL;
          end else if (sh_r == uvh_pkg::CMD_UV) begin
            sq_nxt  = uvh_pkg::SQ_MEAS;
            cnt_nxt = CW'(UV_CYC - 1);
          end
        end
      end
      uvh_pkg::SQ_CAL: begin
        s_we   = 1'b1;
        s_addr = uvh_pkg::REG_CAL_LO + {2'b00, idx_r};
        s_data = CAL_DATA[{idx_r, 3'b000} +: 8];
        if (grant) begin
          idx_nxt = idx_r + 4'h1;
          if (idx_r == uvh_pkg::CAL_LAST) begin
            sq_nxt = uvh_pkg::SQ_DONE;
            rv_nxt = resp_inc;
          end
        end
      end
      uvh_pkg::SQ_MEAS: begin
        if (cnt_r == '0) begin
          uv_nxt = i_uv_x100;
          sq_nxt = uvh_pkg::SQ_AUX;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      uvh_pkg::SQ_AUX: begin
        s_we   = 1'b1;
        s_addr = uvh_pkg::REG_AUX + {5'h00, idx_r[0]};
        s_data = idx_r[0] ? uv_r[15:8] : uv_r[7:0];
        if (grant) begin
          idx_nxt = idx_r + 4'h1;
          if (idx_r[0]) begin
            sq_nxt  = uvh_pkg::SQ_DONE;
            rv_nxt  = resp_inc;
            irq_set = 1'b1;
          end
        end
      end
      uvh_pkg::SQ_DONE: begin
        s_we = 1'b1;
        if (grant) begin
          sq_nxt = uvh_pkg::SQ_STBY;
        end
      end
    endcase
    if (gc_rst) begin
      sq_nxt = uvh_pkg::SQ_OFF;
    end
    // A new event wins over a clear in the same cycle
    irq_nxt = irq_set | (irq_r & ~irq_clr);
    if (sq_r == uvh_pkg::SQ_OFF) begin
      irq_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sq_r  <= uvh_pkg::SQ_OFF;
      cnt_r <= '0;
      idx_r <= 4'h0;
      rv_r  <= 8'h00;
      uv_r  <= 16'h0000;
      irq_r <= 1'b0;
    end else begin
      sq_r  <= sq_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      rv_r  <= rv_nxt;
      uv_r  <= uv_nxt;
      irq_r <= irq_nxt;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 64; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (sq_r == uvh_pkg::SQ_OFF) begin
      for (int i = 0; i < 64; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (wr_en) begin
      mem[ptr_r] <= sh_r;
    end else if (grant) begin
      mem[s_addr] <= s_data;
    end
  end

  // Open-drain interrupt: drive low only while pending
  assign o_int_o  = 1'b0;
  assign o_int_oe = irq_r;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_addr_byte;
    ist_r == uvh_pkg::IS_AACK && fall && !oe_r && !start && !stop;
  endsequence
  property p_int_od;
    @(posedge i_clk_sys) disable iff (i_sys_rst) o_int_o == 1'b0 && o_int_oe == irq_r;
  endproperty
  a_int_od: assert property (p_int_od) else $error("int pin drives high");
  property p_ack_own;
    @(posedge i_clk_sys) disable iff (i_sys_rst) s_addr_byte |=>
      oe_r == ($past(sh_r[7:1]) == uvh_pkg::OWN_ADDR || $past(sh_r) == 8'h00);
  endproperty
  a_ack_own: assert property (p_ack_own) else $error("address ack wrong");
  property p_gc_off;
    @(posedge i_clk_sys) disable iff (i_sys_rst) gc_rst |=> sq_r == uvh_pkg::SQ_OFF
      ##1 sq_r == uvh_pkg::SQ_INIT;
  endproperty
  a_gc_off: assert property (p_gc_off) else $error("reset did not restart");
  property p_init_end;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      sq_r == uvh_pkg::SQ_INIT && cnt_r == '0 && !gc_rst |=> sq_r == uvh_pkg::SQ_STBY;
  endproperty
  a_init_end: assert property (p_init_end) else $error("no standby after init");
  property p_ptr_load;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      ist_r == uvh_pkg::IS_WACK && fall && !oe_r && first_r && !gc_r && !stop && !start
      |=> ptr_r == $past(sh_r[5:0]) && aid_r == $past(sh_r[6]);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer load wrong");
  property p_ai;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      wr_en |=> ptr_r == ($past(aid_r) ? $past(ptr_r) : $past(ptr_r) + 6'h01);
  endproperty
  a_ai: assert property (p_ai) else $error("pointer step wrong");
  property p_wake;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      sq_r == uvh_pkg::SQ_STBY && !cmd_wr && !gc_rst |=> sq_r == uvh_pkg::SQ_STBY;
  endproperty
  a_wake: assert property (p_wake) else $error("woke without command");
  property p_irq_hold;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      sq_r == uvh_pkg::SQ_STBY && !irq_clr && !gc_rst |=> irq_r == $past(irq_r);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt changed");
  property p_uv;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      $rose(irq_r) |-> {mem[uvh_pkg::REG_AUX + 6'h01], mem[uvh_pkg::REG_AUX]} == uv_r;
  endproperty
  a_uv: assert property (p_uv) else $error("aux result wrong");
  property p_cal;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      sq_r == uvh_pkg::SQ_CAL && grant && idx_r == uvh_pkg::CAL_LAST
      |=> mem[uvh_pkg::REG_CAL_LO] == CAL_DATA[7:0] && mem[uvh_pkg::REG_CAL_HI] == CAL_DATA[95:88];
  endproperty
  a_cal: assert property (p_cal) else $error("calibration not loaded");
  property p_resp;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      sq_r == uvh_pkg::SQ_DONE && grant |=> mem[uvh_pkg::REG_RESP] == $past(rv_r);
  endproperty
  a_resp: assert property (p_resp) else $error("reply not written");
endmodule

/* File: include/uvh_pkg.sv */
// Constants and types of the light sensor host port
package uvh_pkg;
  localparam logic [6:0] OWN_ADDR   = 7'h60;
  localparam logic [6:0] GC_ADDR    = 7'h00;
  localparam logic [7:0] GC_RESET   = 8'h06;
  localparam logic [5:0] REG_KEY    = 6'h07;
  localparam logic [5:0] REG_CMD    = 6'h18;
  localparam logic [5:0] REG_RESP   = 6'h20;
  localparam logic [5:0] REG_IRQ    = 6'h21;
  localparam logic [5:0] REG_CAL_LO = 6'h22;
  localparam logic [5:0] REG_CAL_HI = 6'h2D;
  localparam logic [5:0] REG_AUX    = 6'h2C;
  localparam logic [7:0] CMD_NOP    = 8'h00;
  localparam logic [7:0] CMD_RESET  = 8'h01;
  localparam logic [7:0] CMD_UV     = 8'h06;
  localparam logic [7:0] CMD_CAL    = 8'h12;
  localparam logic [7:0] KEY_VAL    = 8'h17;
  localparam logic [3:0] ERR_BADCMD = 4'h8;
  localparam int         AI_BIT     = 6;
  localparam logic [3:0] CAL_LAST   = 4'(REG_CAL_HI - REG_CAL_LO);
  localparam int         CLK_NS     = 25;
  localparam int         UV_NS      = 285000;
  localparam int         INIT_NS    = 25000;
  localparam int         UV_CYC     = (UV_NS + CLK_NS - 1) / CLK_NS;
  localparam int         INIT_CYC   = (INIT_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    SQ_OFF, SQ_INIT, SQ_STBY, SQ_CAL, SQ_MEAS, SQ_AUX, SQ_DONE
  } uvh_seq_t;
  typedef enum logic [2:0] {
    IS_IDLE, IS_ADDR, IS_AACK, IS_WR, IS_WACK, IS_RD, IS_RACK, IS_RNXT
  } uvh_i2c_t;
endpackage

/* File: test/uvh_host_model.sv */
// Behavioural I2C host that masters the sensor port
`timescale 1ns/1ps
module uvh_host_model (
  // Clock
  input  wire logic i_clk_sys,
  // Bus pins
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // SCL idles high between frames, SDA released to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  // One 200 ns bit: data set mid-low, line read just before the fall
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    o_sda = b;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    r = i_sda;
    o_scl = 1'b0;
  endtask

  task automatic start();
    tick(4);
    o_sda = 1'b0;
    tick(4);
    o_scl = 1'b0;
  endtask

  task automatic stop();
    tick(2);
    o_sda = 1'b0;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_sda = 1'b1;
    tick(4);
  endtask

  // Byte out or in; ack_in high releases the ninth bit
  task automatic byte_io(input logic [7:0] d, input logic ack_in,
                         output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, a);
    ack = ~a;
  endtask

  task automatic probe(input logic [7:0] hdr, output logic ack);
    logic [7:0] q;
    start();
    byte_io(hdr, 1'b1, q, ack);
    stop();
  endtask

  // Header, pointer, then n data bytes; ok is the AND of all acknowledges
  task automatic wr(input logic [7:0] hdr, input logic [7:0] ptr,
                    input logic [7:0] d [4], input int n, output logic ok);
    logic [7:0] q;
    logic       a;
    start();
    byte_io(hdr, 1'b1, q, ok);
    byte_io(ptr, 1'b1, q, a);
    ok = ok & a;
    for (int i = 0; i < n; i++) begin
      byte_io(d[i], 1'b1, q, a);
      ok = ok & a;
    end
    stop();
  endtask

  // Pointer-only write, then n bytes read with NACK on the last
  task automatic rd(input logic [7:0] ptr, input int n, output logic [7:0] q [4]);
    logic [7:0] d [4];
    logic       a;
    d = '{default: 8'h00};
    wr({uvh_pkg::OWN_ADDR, 1'b0}, ptr, d, 0, a);
    start();
    byte_io({uvh_pkg::OWN_ADDR, 1'b1}, 1'b1, q[0], a);
    for (int i = 0; i < n; i++) begin
      byte_io(8'hFF, (i == n - 1), q[i], a);
    end
    stop();
  endtask
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the UV sensor host port
`timescale 1ns/1ps
module tb_top;
  localparam logic [95:0] CAL = 96'hC3B2A1908F7E6D5C4B3A2918;
  // Host UV setup: these plain register offsets and bit positions are arbitrary
  localparam logic [5:0]  REG_CHANNEL_LIST    = 6'h10;
  localparam logic [5:0]  REG_RANGE           = 6'h11;
  localparam logic [5:0]  REG_UV_COEF         = 6'h13;
  localparam logic [7:0]  UV_CHANNEL_ENABLE   = 8'h80;
  localparam logic [7:0]  VISIBLE_HIGH_RANGE  = 8'h01;
  localparam logic [7:0]  INFRARED_HIGH_RANGE = 8'h02;
  localparam logic [31:0] UV_COEF             = 32'h00016B7B;
  logic        clk_sys;
  logic        sys_rst;
  logic        scl;
  logic        host_sda;
  logic        sda_line;
  logic        int_line;
  logic        sda_o;
  logic        sda_oe;
  logic        int_o;
  logic        int_oe;
  logic        standby;
  logic [15:0] uv_x100;
  logic [7:0]  wb [4];
  logic [7:0]  rb [4];
  logic [7:0]  exp_b [4];
  logic        ok;
  int          fail_count;
  int          checks_done;

  // Open-drain wires with pull-ups
  assign sda_line = (sda_oe ? sda_o : 1'b1) & host_sda;
  assign int_line = int_oe ? int_o : 1'b1;

  uvh_host_port #(.UV_CYC(20), .INIT_CYC(200), .CAL_DATA(CAL)) dut (
    .i_clk_sys (clk_sys),
    .i_sys_rst (sys_rst),
    .i_scl     (scl),
    .i_sda     (sda_line),
    .o_sda_o   (sda_o),
    .o_sda_oe  (sda_oe),
    .o_int_o   (int_o),
    .o_int_oe  (int_oe),
    .i_uv_x100 (uv_x100),
    .o_standby (standby)
  );

  uvh_host_model host (
    .i_clk_sys (clk_sys),
    .i_sda     (sda_line),
    .o_scl     (scl),
    .o_sda     (host_sda)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] cal_byte(input int i);
    return CAL[8 * i +: 8];
  endfunction

  function automatic logic [7:0] reply(input logic [3:0] err, input logic [3:0] cnt);
    return {err, cnt};
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("fail_count=%0d checks_done=%0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Bounded wait on standby (sel 0) or interrupt (sel 1)
  task automatic wait_for(input int sel, input logic lvl);
    for (int i = 0; i < 4000; i++) begin
      if ((sel == 0 ? standby : int_oe) === lvl) begin
        return;
      end
      @(posedge clk_sys);
      #1;
    end
    fail_count++;
    $display("ERROR t=%0t got=%h exp=%h", $time, ~lvl, lvl);
    conclude();
  endtask

  task automatic put(input logic [5:0] ptr, input logic [7:0] v);
    wb[0] = v;
    host.wr({uvh_pkg::OWN_ADDR, 1'b0}, {2'b00, ptr}, wb, 1, ok);
    chk1(ok, 1'b1);
  endtask

  task automatic get(input logic [5:0] ptr, input logic [7:0] exp);
    host.rd({2'b00, ptr}, 1, rb);
    chk8(rb[0], exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] a;
    fail_count = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    uv_x100 = 16'h0000;
    void'($urandom(32'h89A6BDEC));
    repeat (3) @(posedge clk_sys);
    chk1(sda_oe, 1'b0);
    chk1(standby, 1'b0);
    #1;
    sys_rst = 1'b0;
    wait_for(0, 1'b1);
    // General-call reset before any register access
    host.probe({uvh_pkg::GC_ADDR, 1'b0}, ok);
    chk1(ok, 1'b1);
    host.wr({uvh_pkg::GC_ADDR, 1'b0}, uvh_pkg::GC_RESET, wb, 0, ok);
    chk1(standby, 1'b0);
    wait_for(0, 1'b1);
    // Address decoding
    host.probe({uvh_pkg::OWN_ADDR, 1'b0}, ok);
    chk1(ok, 1'b1);
    for (int i = 0; i < 6; i++) begin
      a = {7'($urandom_range(1, 95)), 1'($urandom)};
      if (i == 0) a = 8'hF0;
      if (i == 1) a = 8'hF7;
      if (i == 2) a = 8'h01;
      host.probe(a, ok);
      chk1(ok, 1'b0);
    end
    // A general-call byte other than reset is taken and ignored
    host.wr({uvh_pkg::GC_ADDR, 1'b0}, 8'h05, wb, 0, ok);
    chk1(ok, 1'b1);
    chk1(standby, 1'b1);
    // Burst write and read back
    for (int i = 0; i < 4; i++) begin
      wb[i] = 8'($urandom);
      exp_b[i] = wb[i];
    end
    host.wr({uvh_pkg::OWN_ADDR, 1'b0}, 8'h00, wb, 4, ok);
    chk1(ok, 1'b1);
    chk1(standby, 1'b1);
    host.rd(8'h00, 4, rb);
    for (int i = 0; i < 4; i++) begin
      chk8(rb[i], exp_b[i]);
    end
    // Increment disabled: both bytes land in register 1, reads repeat register 0
    wb[0] = 8'($urandom);
    wb[1] = 8'($urandom);
    host.wr({uvh_pkg::OWN_ADDR, 1'b0}, 8'h41, wb, 2, ok);
    host.rd(8'h40, 4, rb);
    for (int i = 0; i < 4; i++) begin
      chk8(rb[i], exp_b[0]);
    end
    get(6'h01, wb[1]);
    get(6'h02, exp_b[2]);
    // Calibration recovery
    put(uvh_pkg::REG_KEY, uvh_pkg::KEY_VAL);
    put(uvh_pkg::REG_CMD, uvh_pkg::CMD_CAL);
    wait_for(0, 1'b1);
    for (int k = 0; k < 3; k++) begin
      host.rd({2'b00, uvh_pkg::REG_CAL_LO} + 8'(4 * k), 4, rb);
      for (int j = 0; j < 4; j++) begin
        chk8(rb[j], cal_byte(4 * k + j));
      end
    end
    get(uvh_pkg::REG_RESP, reply(4'h0, 4'h1));
    // UV channel setup and coefficient defaults from the host
    put(REG_CHANNEL_LIST, UV_CHANNEL_ENABLE);
    put(REG_RANGE, VISIBLE_HIGH_RANGE | INFRARED_HIGH_RANGE);
    for (int i = 0; i < 4; i++) begin
      wb[i] = UV_COEF[8 * i +: 8];
    end
    host.wr({uvh_pkg::OWN_ADDR, 1'b0}, {2'b00, REG_UV_COEF}, wb, 4, ok);
    chk1(ok, 1'b1);
    host.rd({2'b00, REG_UV_COEF}, 4, rb);
    for (int i = 0; i < 4; i++) begin
      chk8(rb[i], UV_COEF[8 * i +: 8]);
    end
    get(REG_CHANNEL_LIST, UV_CHANNEL_ENABLE);
    // UV measurement with interrupt
    uv_x100 = 16'($urandom);
    put(uvh_pkg::REG_CMD, uvh_pkg::CMD_UV);
    wait_for(1, 1'b1);
    chk1(int_line, 1'b0);
    host.rd({2'b00, uvh_pkg::REG_AUX}, 2, rb);
    chk8(rb[0], uv_x100[7:0]);
    chk8(rb[1], uv_x100[15:8]);
    get(uvh_pkg::REG_RESP, reply(4'h0, 4'h2));
    chk1(int_oe, 1'b1);
    get(uvh_pkg::REG_IRQ, 8'h01);
    put(uvh_pkg::REG_IRQ, 8'h01);
    chk1(int_line, 1'b1);
    get(uvh_pkg::REG_IRQ, 8'h00);
    // Bad command and NOP
    put(uvh_pkg::REG_CMD, 8'h33);
    wait_for(0, 1'b1);
    get(uvh_pkg::REG_RESP, reply(uvh_pkg::ERR_BADCMD, 4'h3));
    put(uvh_pkg::REG_CMD, uvh_pkg::CMD_NOP);
    wait_for(0, 1'b1);
    get(uvh_pkg::REG_RESP, 8'h00);
    // Software reset clears the registers
    wb[0] = uvh_pkg::CMD_RESET;
    host.wr({uvh_pkg::OWN_ADDR, 1'b0}, {2'b00, uvh_pkg::REG_CMD}, wb, 1, ok);
    chk1(standby, 1'b0);
    wait_for(0, 1'b1);
    get(6'h00, 8'h00);
    // Key cleared by the reset: a command is stored but never run
    put(uvh_pkg::REG_CMD, uvh_pkg::CMD_CAL);
    chk1(standby, 1'b1);
    get(uvh_pkg::REG_CMD, uvh_pkg::CMD_CAL);
    get(uvh_pkg::REG_RESP, 8'h00);
    get(uvh_pkg::REG_CAL_LO, 8'h00);
    conclude();
  end
endmodule
